// *** rtl/caf_top.sv ***
`include "caf_consts.svh"

module caf_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic init_request_bit,
    input wire logic init_ack_bit,
    output logic sleep_request_bit,
    input wire logic sleep_ack_bit,
    input wire logic [7:0] rx_error_count,
    input wire logic [7:0] tx_error_count,
    input wire logic busoff_enter,
    input wire logic recessive_seq_seen,
    output logic busoff_state,
    input wire logic frame_valid,
    input wire logic [31:0] frame_identifier_bytes,
    input wire logic frame_ide,
    output logic rx_accept,
    output logic [31:0] foreground_rx_buffer,
    output logic foreground_ide,
    output logic [2:0] filter_hit_index,
    output logic irq
);
    import caf_pkg::*;

    caf_state_t s;
    caf_state_t next_s;
    caf_filt_if fif ();

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_do;
    logic [5:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic init_mode;
    logic clr_hold;
    logic [2:0] irq_set;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic reg_mapped(input logic [5:0] idx);
        return (idx == `CAF_IDX_MISC) || (idx == `CAF_IDX_RX_ERROR_COUNT)
            || (idx == `CAF_IDX_TX_ERROR_COUNT)
            || (idx >= `CAF_IDX_CODE0 && idx <= `CAF_IDX_IRQ_MASK);
    endfunction : reg_mapped

    function automatic logic [7:0] reg_read(input caf_state_t st, input logic [5:0] idx,
        input logic iak, input logic sak);
        logic [7:0] v;
        v = `CAF_RST_BYTE;
        if (idx == `CAF_IDX_MISC) begin
            v[`CAF_MISC_HOLD] = (st.bus == CAF_OFF_HOLD);
        end else if (idx == `CAF_IDX_RX_ERROR_COUNT) begin
            v = st.rx_err;
        end else if (idx == `CAF_IDX_TX_ERROR_COUNT) begin
            v = st.tx_err;
        end else if (idx >= `CAF_IDX_CODE0 && idx < `CAF_IDX_MASK0) begin
            v = st.code[idx[1:0]];
        end else if (idx >= `CAF_IDX_MASK0 && idx < `CAF_IDX_CODE4) begin
            v = st.mask[idx[1:0]];
        end else if (idx >= `CAF_IDX_CODE4 && idx < `CAF_IDX_MASK4) begin
            v = st.code[{1'b1, idx[1:0]}];
        end else if (idx >= `CAF_IDX_MASK4 && idx < `CAF_IDX_CTRL) begin
            v = st.mask[{1'b1, idx[1:0]}];
        end else if (idx == `CAF_IDX_CTRL) begin
            v[`CAF_CTRL_INIT_REQ] = st.init_req;
            v[`CAF_CTRL_SLEEP_REQ] = st.sleep_req;
            v[`CAF_CTRL_RECOV_SEL] = st.recov_sel;
            v[`CAF_CTRL_ORG_HI:`CAF_CTRL_ORG_LO] = st.org;
        end else if (idx == `CAF_IDX_STAT) begin
            v[`CAF_STAT_INIT_ACK] = iak;
            v[`CAF_STAT_SLEEP_ACK] = sak;
            v[`CAF_STAT_BUSOFF] = (st.bus != CAF_ACTIVE);
            v[`CAF_STAT_HIT_HI:`CAF_STAT_HIT_LO] = st.hit;
        end else if (idx == `CAF_IDX_IRQ_STAT) begin
            v[`CAF_IRQ_W-1:0] = st.irq_stat;
        end else if (idx == `CAF_IDX_IRQ_MASK) begin
            v[`CAF_IRQ_W-1:0] = st.irq_mask;
        end
        return v;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshakes

    assign s_axi_awready = ~s.aw_hold & ~s.bvalid;
    assign s_axi_wready = ~s.w_hold & ~s.bvalid;
    assign s_axi_arready = ~s.rvalid;
    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire = s_axi_wvalid & s_axi_wready;
    assign ar_fire = s_axi_arvalid & s_axi_arready;

    // Address and data may come in either order; write once both are held or arriving this cycle
    assign wr_do = (s.aw_hold | aw_fire) & (s.w_hold | w_fire);
    assign wr_idx = s.aw_hold ? s.aw_idx : s_axi_awaddr[7:2];
    assign wr_data = s.w_hold ? s.w_data : s_axi_wdata[7:0];
    assign wr_lane0 = s.w_hold ? s.w_lane0 : s_axi_wstrb[0];

    assign init_mode = s.init_req & init_ack_bit;
    assign clr_hold = wr_do & wr_lane0 & (wr_idx == `CAF_IDX_MISC)
        & wr_data[`CAF_MISC_HOLD];

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance filter

    assign fif.code = s.code;
    assign fif.mask = s.mask;
    assign fif.id = s.bg_id;
    assign fif.ide = s.bg_ide;
    assign fif.org = s.org;

    caf_filter u_filter (
        .fi(fif.filt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        irq_set = `CAF_RST_IRQ;

        // Write channel
        if (aw_fire) begin
            next_s.aw_hold = 1'b1;
            next_s.aw_idx = s_axi_awaddr[7:2];
        end
        if (w_fire) begin
            next_s.w_hold = 1'b1;
            next_s.w_data = s_axi_wdata[7:0];
            next_s.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_do) begin
            next_s.aw_hold = 1'b0;
            next_s.w_hold = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = reg_mapped(wr_idx) ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
            if (wr_lane0) begin
                if (init_mode) begin
                    if (wr_idx >= `CAF_IDX_CODE0 && wr_idx < `CAF_IDX_MASK0) begin
                        next_s.code[wr_idx[1:0]] = wr_data;
                    end else if (wr_idx >= `CAF_IDX_MASK0 && wr_idx < `CAF_IDX_CODE4) begin
                        next_s.mask[wr_idx[1:0]] = wr_data;
                    end else if (wr_idx >= `CAF_IDX_CODE4 && wr_idx < `CAF_IDX_MASK4) begin
                        next_s.code[{1'b1, wr_idx[1:0]}] = wr_data;
                    end else if (wr_idx >= `CAF_IDX_MASK4 && wr_idx < `CAF_IDX_CTRL) begin
                        next_s.mask[{1'b1, wr_idx[1:0]}] = wr_data;
                    end
                end
                if (wr_idx == `CAF_IDX_CTRL) begin
                    next_s.init_req = wr_data[`CAF_CTRL_INIT_REQ];
                    next_s.sleep_req = wr_data[`CAF_CTRL_SLEEP_REQ];
                    if (init_mode) begin
                        next_s.recov_sel = wr_data[`CAF_CTRL_RECOV_SEL];
                        next_s.org = caf_org_t'(wr_data[`CAF_CTRL_ORG_HI:`CAF_CTRL_ORG_LO]);
                    end
                end
                if (wr_idx == `CAF_IDX_IRQ_STAT) begin
                    next_s.irq_stat = s.irq_stat & ~wr_data[`CAF_IRQ_W-1:0];
                end
                if (wr_idx == `CAF_IDX_IRQ_MASK) begin
                    next_s.irq_mask = wr_data[`CAF_IRQ_W-1:0];
                end
            end
        end

        // Read channel
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = reg_read(s, s_axi_araddr[7:2], init_ack_bit, sleep_ack_bit);
            next_s.rresp = reg_mapped(s_axi_araddr[7:2]) ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
        end

        // Error counters mirror the protocol engine
        next_s.rx_err = rx_error_count;
        next_s.tx_err = tx_error_count;

        // Bus-off state
        case (s.bus)
            CAF_ACTIVE: begin
                next_s.seq_cnt = `CAF_RST_BYTE;
                if (busoff_enter) begin
                    next_s.bus = s.recov_sel ? CAF_OFF_HOLD : CAF_OFF_COUNT;
                    irq_set[`CAF_IRQ_BUSOFF] = 1'b1;
                end
            end
            CAF_OFF_HOLD: begin
                // A new bus-off event in the clearing cycle keeps the hold
                if (clr_hold && !busoff_enter) begin
                    next_s.bus = CAF_OFF_COUNT;
                end
            end
            CAF_OFF_COUNT: begin
                if (recessive_seq_seen) begin
                    if (s.seq_cnt == `CAF_SEQ_LAST) begin
                        next_s.bus = CAF_ACTIVE;
                        next_s.seq_cnt = `CAF_RST_BYTE;
                        irq_set[`CAF_IRQ_RECOVER] = 1'b1;
                    end else begin
                        next_s.seq_cnt = s.seq_cnt + 8'h01;
                    end
                end
            end
            default: begin
                next_s.bus = CAF_ACTIVE;
            end
        endcase

        // Receive path: background buffer, then filter, then foreground
        next_s.acc_pulse = 1'b0;
        next_s.bg_pending = 1'b0;
        if (s.bg_pending && fif.accept) begin
            next_s.fg_id = s.bg_id;
            next_s.fg_ide = s.bg_ide;
            next_s.hit = fif.hit;
            next_s.acc_pulse = 1'b1;
            irq_set[`CAF_IRQ_ACCEPT] = 1'b1;
        end
        if (frame_valid) begin
            next_s.bg_id = frame_identifier_bytes;
            next_s.bg_ide = frame_ide;
            next_s.bg_pending = 1'b1;
        end

        // Events win over a same-cycle clear
        next_s.irq_stat = next_s.irq_stat | irq_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = {24'h000000, s.rdata};
    assign s_axi_rresp = s.rresp;
    assign init_request_bit = s.init_req;
    assign sleep_request_bit = s.sleep_req;
    assign busoff_state = (s.bus != CAF_ACTIVE);
    assign rx_accept = s.acc_pulse;
    assign foreground_rx_buffer = s.fg_id;
    assign foreground_ide = s.fg_ide;
    assign filter_hit_index = s.hit;
    assign irq = |(s.irq_stat & s.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_hold_set;
        @(posedge aclk) disable iff (!aresetn)
        (s.bus == CAF_ACTIVE && busoff_enter && s.recov_sel) |=> (s.bus == CAF_OFF_HOLD);
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("hold flag not set");

    property p_hold_keep;
        @(posedge aclk) disable iff (!aresetn)
        (s.bus == CAF_OFF_HOLD && !clr_hold) |=> (s.bus == CAF_OFF_HOLD);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold left early");

    property p_hold_clear;
        @(posedge aclk) disable iff (!aresetn)
        (s.bus == CAF_OFF_HOLD && clr_hold && !busoff_enter) |=> (s.bus == CAF_OFF_COUNT);
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("w1c ignored");

    property p_rx_error_count_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_fire && s_axi_araddr[7:2] == `CAF_IDX_RX_ERROR_COUNT) |=> (s.rdata == $past(s.rx_err));
    endproperty
    a_rx_error_count_read: assert property (p_rx_error_count_read) else $error("rx count read wrong");

    property p_tx_error_count_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_fire && s_axi_araddr[7:2] == `CAF_IDX_TX_ERROR_COUNT) |=> (s.rdata == $past(s.tx_err));
    endproperty
    a_tx_error_count_read: assert property (p_tx_error_count_read) else $error("tx count read wrong");

    property p_filter_locked;
        @(posedge aclk) disable iff (!aresetn)
        !init_mode |=> ($stable(s.code) && $stable(s.mask));
    endproperty
    a_filter_locked: assert property (p_filter_locked) else $error("filter written");

    property p_fg_load;
        @(posedge aclk) disable iff (!aresetn)
        (s.bg_pending && fif.accept) |=> (s.fg_id == $past(s.bg_id) && s.hit == $past(fif.hit)
            && rx_accept);
    endproperty
    a_fg_load: assert property (p_fg_load) else $error("foreground not loaded");

    property p_closed;
        @(posedge aclk) disable iff (!aresetn)
        (s.org == CAF_CLOSED) |-> !fif.accept;
    endproperty
    a_closed: assert property (p_closed) else $error("closed filter accepted");

    property p_recover;
        @(posedge aclk) disable iff (!aresetn)
        (s.bus == CAF_OFF_COUNT) ##1 (s.bus == CAF_ACTIVE)
            |-> ($past(recessive_seq_seen) && $past(s.seq_cnt) == `CAF_SEQ_LAST);
    endproperty
    a_recover: assert property (p_recover) else $error("bus-off left early");

endmodule : caf_top

// *** common/caf_consts.svh ***
`ifndef CAF_CONSTS_SVH
`define CAF_CONSTS_SVH

// Register word indices, byte address is index times four
`define CAF_IDX_MISC 6'h0b
`define CAF_IDX_RX_ERROR_COUNT 6'h0e
`define CAF_IDX_TX_ERROR_COUNT 6'h0f
`define CAF_IDX_CODE0 6'h10
`define CAF_IDX_MASK0 6'h14
`define CAF_IDX_CODE4 6'h18
`define CAF_IDX_MASK4 6'h1c
`define CAF_IDX_CTRL 6'h20
`define CAF_IDX_STAT 6'h21
`define CAF_IDX_IRQ_STAT 6'h22
`define CAF_IDX_IRQ_MASK 6'h23

// Control register fields
`define CAF_CTRL_INIT_REQ 0
`define CAF_CTRL_SLEEP_REQ 1
`define CAF_CTRL_RECOV_SEL 2
`define CAF_CTRL_ORG_LO 4
`define CAF_CTRL_ORG_HI 5

// Status register fields
`define CAF_STAT_INIT_ACK 0
`define CAF_STAT_SLEEP_ACK 1
`define CAF_STAT_BUSOFF 2
`define CAF_STAT_HIT_LO 4
`define CAF_STAT_HIT_HI 6

// Miscellaneous register field
`define CAF_MISC_HOLD 0

// Interrupt bits
`define CAF_IRQ_ACCEPT 0
`define CAF_IRQ_BUSOFF 1
`define CAF_IRQ_RECOVER 2
`define CAF_IRQ_W 3

// Reset values and counts
`define CAF_RST_BYTE 8'h00
`define CAF_RST_IRQ 3'h0
`define CAF_SEQ_LAST 8'h7f
`define CAF_RESP_OKAY 2'h0
`define CAF_RESP_SLVERR 2'h2

`endif

// *** common/caf_pkg.sv ***
package caf_pkg;

    typedef enum logic [1:0] {
        CAF_ORG32,
        CAF_ORG16,
        CAF_ORG8,
        CAF_CLOSED
    } caf_org_t;

    typedef enum logic [1:0] {
        CAF_ACTIVE,
        CAF_OFF_HOLD,
        CAF_OFF_COUNT
    } caf_bus_t;

    typedef struct packed {
        logic aw_hold;
        logic [5:0] aw_idx;
        logic w_hold;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0][7:0] code;
        logic [7:0][7:0] mask;
        logic init_req;
        logic sleep_req;
        logic recov_sel;
        caf_org_t org;
        logic [7:0] rx_err;
        logic [7:0] tx_err;
        caf_bus_t bus;
        logic [7:0] seq_cnt;
        logic [31:0] bg_id;
        logic bg_ide;
        logic bg_pending;
        logic [31:0] fg_id;
        logic fg_ide;
        logic [2:0] hit;
        logic acc_pulse;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
    } caf_state_t;

endpackage : caf_pkg

// *** common/caf_filt_if.sv ***
interface caf_filt_if;
    import caf_pkg::*;

    logic [7:0][7:0] code;
    logic [7:0][7:0] mask;
    logic [0:3][7:0] id;
    logic ide;
    caf_org_t org;
    logic accept;
    logic [2:0] hit;

    modport ctrl (output code, output mask, output id, output ide, output org,
        input accept, input hit);
    modport filt (input code, input mask, input id, input ide, input org,
        output accept, output hit);
endinterface : caf_filt_if

// *** rtl/caf_filter.sv ***
module caf_filter (
    caf_filt_if.filt fi
);
    import caf_pkg::*;

    // Unmasked bits of one byte all agree with the code
    function automatic logic byte_match(input logic [7:0] c, input logic [7:0] m,
        input logic [7:0] id);
        return &(~(c ^ id) | m);
    endfunction : byte_match

    logic [7:0][3:0] bm;
    logic [7:0] fhit;

    // Every code byte against every identifier byte, bit by bit
    generate
        for (genvar k = 0; k < 8; k++) begin : g_code
            for (genvar j = 0; j < 4; j++) begin : g_id
                assign bm[k][j] = byte_match(fi.code[k], fi.mask[k], fi.id[j]);
            end
        end
    endgenerate

    always_comb begin
        fhit = 8'h00;
        case (fi.org)
            CAF_ORG32: begin
                for (int f = 0; f < 2; f++) begin
                    // Standard frames use only the first two bytes
                    fhit[f] = bm[4*f][0] & bm[4*f+1][1]
                        & (~fi.ide | (bm[4*f+2][2] & bm[4*f+3][3]));
                end
            end
            CAF_ORG16: begin
                for (int f = 0; f < 4; f++) begin
                    fhit[f] = bm[2*f][0] & bm[2*f+1][1];
                end
            end
            CAF_ORG8: begin
                for (int f = 0; f < 8; f++) begin
                    fhit[f] = bm[f][0];
                end
            end
            default: begin
                fhit = 8'h00;
            end
        endcase
    end

    // Lowest numbered matching filter reports the hit
    always_comb begin
        fi.hit = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (fhit[i]) begin
                fi.hit = 3'(i);
            end
        end
    end

    assign fi.accept = |fhit;

endmodule : caf_filter

// *** verif/caf_node_model.sv ***
module caf_node_model (
    input wire logic aclk,
    input wire logic init_request_bit,
    input wire logic sleep_request_bit,
    output logic init_ack_bit,
    output logic sleep_ack_bit,
    output logic [7:0] rx_error_count,
    output logic [7:0] tx_error_count,
    output logic busoff_enter,
    output logic recessive_seq_seen,
    output logic frame_valid,
    output logic [31:0] frame_identifier_bytes,
    output logic frame_ide
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ireq_d;
    logic [1:0] sreq_d;

    initial begin
        {rx_error_count, tx_error_count} = 16'h0;
        {busoff_enter, recessive_seq_seen, frame_valid, frame_ide} = 4'h0;
        frame_identifier_bytes = 32'h0;
    end

    // Mode acknowledges trail their requests by three cycles
    always @(posedge aclk) begin
        ireq_d <= {ireq_d[0], init_request_bit};
        sreq_d <= {sreq_d[0], sleep_request_bit};
        init_ack_bit <= ireq_d[1];
        sleep_ack_bit <= sreq_d[1];
    end

    task set_err(input logic [7:0] rx, input logic [7:0] tx);
        @(posedge aclk);
        rx_error_count <= rx;
        tx_error_count <= tx;
    endtask : set_err

    // Lines show the inverse once the frame is gone, never the stale identifier
    task send_frame(input logic [31:0] id, input logic ide);
        @(posedge aclk);
        frame_valid <= 1'h1;
        frame_identifier_bytes <= id;
        frame_ide <= ide;
        @(posedge aclk);
        frame_valid <= 1'h0;
        frame_identifier_bytes <= ~id;
        frame_ide <= ~ide;
    endtask : send_frame

    task pulse_off();
        @(posedge aclk);
        busoff_enter <= 1'h1;
        @(posedge aclk);
        busoff_enter <= 1'h0;
    endtask : pulse_off

    task pulse_rec(input int n);
        repeat (n) begin
            @(posedge aclk);
            recessive_seq_seen <= 1'h1;
            @(posedge aclk);
            recessive_seq_seen <= 1'h0;
        end
    endtask : pulse_rec
endmodule : caf_node_model

// *** verif/test_can_acceptance_filter_status.sv ***
module test_can_acceptance_filter_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, ireq, iack, sreq, sack;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, fg, fid;
    logic [7:0] rxe, txe;
    logic boe, rss, bst, fv, fide, acc, fgide, irq;
    logic [2:0] hit;
    int n_mismatch = 0;
    int checks_done = 0;

    always #2 aclk = ~aclk;

    caf_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .init_request_bit(ireq), .init_ack_bit(iack), .sleep_request_bit(sreq),
        .sleep_ack_bit(sack), .rx_error_count(rxe), .tx_error_count(txe), .busoff_enter(boe),
        .recessive_seq_seen(rss), .busoff_state(bst), .frame_valid(fv),
        .frame_identifier_bytes(fid), .frame_ide(fide), .rx_accept(acc),
        .foreground_rx_buffer(fg), .foreground_ide(fgide), .filter_hit_index(hit), .irq(irq)
    );

    caf_node_model node (
        .aclk(aclk), .init_request_bit(ireq), .sleep_request_bit(sreq), .init_ack_bit(iack),
        .sleep_ack_bit(sack), .rx_error_count(rxe), .tx_error_count(txe), .busoff_enter(boe),
        .recessive_seq_seen(rss), .frame_valid(fv), .frame_identifier_bytes(fid),
        .frame_ide(fide)
    );

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic tmo();
        n_mismatch++;
        $display("BAD %0t wait ran out", $time);
        results();
    endtask : tmo

    // Handshakes are judged mid-cycle, which equals sampling at the next rising edge
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic haw, hw, hb;
        logic [1:0] r;
        int n;
        n = 0;
        hb = 1'h0;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (hb !== 1'h1) begin
            @(negedge aclk);
            haw = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (haw) awvalid <= 1'h0;
            if (hw) wvalid <= 1'h0;
            if (++n > 40) tmo();
        end
        bready <= 1'h0;
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask : wr

    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic har, hr;
        int n;
        n = 0;
        hr = 1'h0;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (hr !== 1'h1) begin
            @(negedge aclk);
            har = arvalid && arready;
            hr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (har) arvalid <= 1'h0;
            if (++n > 40) tmo();
        end
        rready <= 1'h0;
    endtask : rd

    task automatic rc(input logic [5:0] idx, input logic [7:0] e, input string m);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, {24'h0, e}, m);
        chk({30'h0, r}, 32'h0, m);
    endtask : rc

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rc(6'h0e, 8'h00, "rx count reset");
        rc(6'h0f, 8'h00, "tx count reset");
        for (int i = 0; i < 16; i++) rc(6'h10 + i[5:0], 8'h00, "filter reset");
        rd(6'h3f, d, r);
        chk({30'h0, r}, 32'h2, "unmapped read");
        wr(6'h3e, 8'h01, 2'h2);
        wr(6'h10, 8'h5a, 2'h0);
        rc(6'h10, 8'h00, "code written outside init");
        $display("reset test done");
    endtask : t_reset

    task automatic t_count();
        int n;
        n = 0;
        node.set_err(8'h5a, 8'ha5);
        wr(6'h20, 8'h03, 2'h0);
        while (iack !== 1'h1 || sack !== 1'h1) begin
            @(posedge aclk);
            if (++n > 20) tmo();
        end
        rc(6'h21, 8'h03, "status in init and sleep");
        rc(6'h0e, 8'h5a, "rx count");
        rc(6'h0f, 8'ha5, "tx count");
        wr(6'h0e, 8'hff, 2'h0);
        rc(6'h0e, 8'h5a, "rx count after write");
        $display("counter test done");
    endtask : t_count

    // Masks of bytes 1,3,5 ignore the three low bits and byte 7 the four low bits so standard frames can pass
    task automatic t_filt();
        logic [7:0] cd [16] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h07, 8'h00, 8'h07,
            8'ha0, 8'hb0, 8'hc0, 8'hd0, 8'h00, 8'h07, 8'h00, 8'h0f};
        logic [47:0] tv [9] = '{48'h0_11223344_1_1_0, 48'h0_a0b0c0d5_1_1_1,
            48'h0_11223b44_1_0_0, 48'h0_1125ffff_0_1_0, 48'h1_33440000_1_1_1,
            48'h1_c0d50000_1_1_3, 48'h2_c0000000_1_1_6, 48'h2_d3000000_1_1_7,
            48'h3_11223344_1_0_0};
        logic [31:0] last;
        logic [3:0] lh;
        logic got;
        last = 32'h0;
        lh = 4'h0;
        for (int i = 0; i < 16; i++) wr(6'h10 + i[5:0], cd[i], 2'h0);
        for (int i = 0; i < 16; i++) rc(6'h10 + i[5:0], cd[i], "filter readback");
        wr(6'h23, 8'h07, 2'h0);
        for (int i = 0; i < 9; i++) begin
            wr(6'h20, {2'h0, tv[i][45:44], 4'h1}, 2'h0);
            node.send_frame(tv[i][43:12], tv[i][8]);
            got = 1'h0;
            repeat (4) begin
                @(negedge aclk);
                if (acc === 1'h1) got = 1'h1;
            end
            if (tv[i][4]) last = tv[i][43:12];
            if (tv[i][4]) lh = {tv[i][8], tv[i][2:0]};
            chk({31'h0, got}, {31'h0, tv[i][4]}, "accept");
            chk(fg, last, "foreground");
            chk({28'h0, fgide, hit}, {28'h0, lh}, "hit index and ide");
        end
        $display("filter test done");
    endtask : t_filt

    task automatic t_irq();
        @(negedge aclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(6'h23, 8'h00, 2'h0);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(6'h23, 8'h07, 2'h0);
        wr(6'h22, 8'h01, 2'h0);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_busoff();
        wr(6'h20, 8'h05, 2'h0);
        node.pulse_off();
        node.pulse_rec(130);
        @(negedge aclk);
        chk({31'h0, bst}, 32'h1, "held in bus-off");
        rc(6'h0b, 8'h01, "hold flag set");
        wr(6'h0b, 8'h00, 2'h0);
        rc(6'h0b, 8'h01, "hold after zero write");
        wr(6'h0b, 8'h01, 2'h0);
        rc(6'h0b, 8'h00, "hold cleared");
        node.pulse_rec(127);
        repeat (2) @(negedge aclk);
        chk({31'h0, bst}, 32'h1, "bus-off before last sequence");
        node.pulse_rec(1);
        repeat (2) @(negedge aclk);
        chk({31'h0, bst}, 32'h0, "bus-off left");
        rc(6'h22, 8'h06, "bus-off events");
        $display("bus-off test done");
    endtask : t_busoff

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_count();
        t_filt();
        t_irq();
        t_busoff();
        results();
    end
endmodule : test_can_acceptance_filter_status
